// ### fcm_pkg.sv
// Constants and types for the flash command host controller.
// Assumes a parallel NOR flash on the far side of the pins, one clock domain here.
// Summary of operation
// - Write cycle needs chip select and write strobe low, output enable high.
// - Host writes reset command to leave autoselect or error status.
// - Two unlocks plus autoselect command enter autoselect until reset.
// - Standard program is two unlocks, set-up, then address and data.
// - Two unlocks then 20h enter unlock bypass mode.
// - In bypass, A0h then address and data programs a location.
// - Bypass exit is 90h then 00h at any address.
package fcm_pkg;

    localparam logic [3:0] FCM_OP_READ      = 4'h0;
    localparam logic [3:0] FCM_OP_RESET     = 4'h1;
    localparam logic [3:0] FCM_OP_AUTOSEL   = 4'h2;
    localparam logic [3:0] FCM_OP_PROGRAM   = 4'h3;
    localparam logic [3:0] FCM_OP_BYP_ENTER = 4'h4;
    localparam logic [3:0] FCM_OP_BYP_PROG  = 4'h5;
    localparam logic [3:0] FCM_OP_BYP_EXIT  = 4'h6;

    localparam logic [7:0] FCM_CMD_BYP_ENTER = 8'h20;
    localparam logic [7:0] FCM_CMD_BYP_PROG  = 8'ha0;
    localparam logic [7:0] FCM_CMD_BYP_EXIT1 = 8'h90;
    localparam logic [7:0] FCM_CMD_BYP_EXIT2 = 8'h00;

    // Autoselect low addresses, word mode / byte mode
    localparam logic [7:0] FCM_AS_MAKER_ADDR  = 8'h00;
    localparam logic [7:0] FCM_AS_DEV_WORD    = 8'h01;
    localparam logic [7:0] FCM_AS_DEV_BYTE    = 8'h02;
    localparam logic [7:0] FCM_AS_PROT_WORD   = 8'h02;
    localparam logic [7:0] FCM_AS_PROT_BYTE   = 8'h04;
    localparam logic [7:0] FCM_AS_PROTECTED   = 8'h01;

    // Bus cycle phase lengths in clock cycles
    localparam int FCM_CLK_MHZ      = 250;
    localparam int FCM_SETUP_NS     = 12;
    localparam int FCM_PULSE_NS     = 40;
    localparam int FCM_HOLD_NS      = 12;
    localparam logic [3:0] FCM_SETUP_CYC = 4'((FCM_SETUP_NS * FCM_CLK_MHZ + 999) / 1000);
    localparam logic [3:0] FCM_PULSE_CYC = 4'((FCM_PULSE_NS * FCM_CLK_MHZ + 999) / 1000);
    localparam logic [3:0] FCM_HOLD_CYC  = 4'((FCM_HOLD_NS * FCM_CLK_MHZ + 999) / 1000);

    typedef enum logic [2:0] {
        FCM_BUS_IDLE,
        FCM_BUS_SETUP,
        FCM_BUS_PULSE,
        FCM_BUS_HOLD,
        FCM_BUS_DONE
    } fcm_bus_state_type;

    typedef enum logic [2:0] {
        FCM_ST_IDLE,
        FCM_ST_ISSUE,
        FCM_ST_WAIT_BUS,
        FCM_ST_WAIT_BUSY,
        FCM_ST_WAIT_READY,
        FCM_ST_FINISH
    } fcm_state_type;

endpackage

// ### fcm_bus_cycle.sv
// One parallel flash bus cycle (read or write) on the chip pins.
// Assumes the device answers reads within the strobe pulse time.
`timescale 1ns/1ns
`default_nettype none
module fcm_bus_cycle
    import fcm_pkg::*;
#(
    parameter int AW = 19,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          srst,
    // Cycle request
    input  wire logic          start,
    input  wire logic          is_write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    // Flash pins
    output logic [AW-1:0]      flash_addr,
    output logic               chip_sel_n,
    output logic               out_en_n,
    output logic               write_n,
    output logic [DW-1:0]      dq_out,
    output logic               dq_oe,
    input  wire logic [DW-1:0] dq_in
);

    typedef struct packed {
        fcm_bus_state_type st;
        logic [3:0]        cnt;
        logic              wr;
        logic [AW-1:0]     addr;
        logic [DW-1:0]     wdata;
        logic [DW-1:0]     s1;
        logic [DW-1:0]     s2;
        logic              done;
        logic              cs_n;
        logic              oe_n;
        logic              we_n;
        logic              dq_oe;
        logic [DW-1:0]     rdata;
    } fcm_bus_reg_type;

    fcm_bus_reg_type q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.s1 = dq_in;
        d.s2 = q.s1;
        case (q.st)
            FCM_BUS_IDLE: begin
                if (start) begin
                    d.wr = is_write;
                    d.addr = addr;
                    d.wdata = wdata;
                    d.cnt = FCM_SETUP_CYC;
                    d.dq_oe = is_write;
                    d.st = FCM_BUS_SETUP;
                end
            end
            FCM_BUS_SETUP: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    // strobe with output enable high on writes
                    d.cs_n = 1'b0;
                    d.we_n = !q.wr;
                    d.oe_n = q.wr;
                    d.cnt = FCM_PULSE_CYC;
                    d.st = FCM_BUS_PULSE;
                end
            end
            FCM_BUS_PULSE: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    // address and data held across both strobe edges
                    d.cs_n = 1'b1;
                    // Read data from the synchronised sample as the pulse ends
                    if (!q.wr) d.rdata = q.s2;
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.cnt = FCM_HOLD_CYC;
                    d.st = FCM_BUS_HOLD;
                end
            end
            FCM_BUS_HOLD: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.dq_oe = 1'b0;
                    d.st = FCM_BUS_DONE;
                end
            end
            FCM_BUS_DONE: begin
                d.done = 1'b1;
                d.st = FCM_BUS_IDLE;
            end
            default: d.st = FCM_BUS_IDLE;
        endcase
        if (srst) begin
            d = '0;
            d.st = FCM_BUS_IDLE;
            d.cs_n = 1'b1;
            d.oe_n = 1'b1;
            d.we_n = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign done       = q.done;
    assign rdata      = q.rdata;
    assign flash_addr = q.addr;
    assign chip_sel_n = q.cs_n;
    assign out_en_n   = q.oe_n;
    assign write_n    = q.we_n;
    assign dq_out     = q.wdata;
    assign dq_oe      = q.dq_oe;

endmodule
`default_nettype wire

// ### fcm_host.sv
// Host-side command sequencer for a parallel NOR flash.
// Assumes one request at a time; busy status comes from the flash pin.
`timescale 1ns/1ns
`default_nettype none
module fcm_host
    import fcm_pkg::*;
#(
    parameter int              AW           = 19,
    parameter int              DW           = 16,
    parameter logic [18:0]     UNLOCK1_ADDR = 19'h00555,
    parameter logic [7:0]      UNLOCK1_DATA = 8'haa,
    parameter logic [18:0]     UNLOCK2_ADDR = 19'h002aa,
    parameter logic [7:0]      UNLOCK2_DATA = 8'h55,
    parameter logic [7:0]      CMD_RESET    = 8'hf0,
    parameter logic [7:0]      CMD_AUTOSEL  = 8'h90,
    parameter logic [7:0]      CMD_PROG     = 8'ha0,
    parameter int              BUSY_WAIT    = 64,
    parameter int              BUSY_TIMEOUT = 65536
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          srst,
    // User request
    input  wire logic          req_valid,
    input  wire logic [3:0]    req_op,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_data,
    output logic               req_ready,
    // User answer
    output logic               resp_valid,
    output logic [DW-1:0]      resp_data,
    output logic               resp_timeout,
    output logic               in_bypass,
    output logic               in_autoselect,
    // Flash pins
    output logic [AW-1:0]      flash_addr,
    output logic               chip_sel_n,
    output logic               out_en_n,
    output logic               write_n,
    output logic [DW-1:0]      dq_out,
    output logic               dq_oe,
    input  wire logic [DW-1:0] dq_in,
    input  wire logic          ready_busy_n
);

    typedef struct packed {
        fcm_state_type st;
        logic [3:0]    op;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [1:0]    step;
        logic [16:0]   wait_cnt;
        logic          start;
        logic          wr;
        logic [AW-1:0] baddr;
        logic [DW-1:0] bdata;
        logic          rdy;
        logic          rvalid;
        logic [DW-1:0] rdata;
        logic          tout;
        logic          byp;
        logic          asel;
        logic          rb1;
        logic          rb2;
    } fcm_host_reg_type;

    fcm_host_reg_type q, d;
    logic             bus_done;
    logic [DW-1:0]    bus_rdata;

    // Index of the last bus cycle (cycle count minus one) for each operation
    function automatic logic [1:0] last_step(input logic [3:0] op);
        case (op)
            FCM_OP_AUTOSEL, FCM_OP_BYP_ENTER: last_step = 2'd2;
            FCM_OP_PROGRAM:                   last_step = 2'd3;
            FCM_OP_BYP_PROG, FCM_OP_BYP_EXIT: last_step = 2'd1;
            default:                          last_step = 2'd0;
        endcase
    endfunction

    function automatic logic [DW-1:0] cmd(input logic [7:0] v);
        cmd = DW'(v);
    endfunction

    always_comb begin
        d = q;
        d.start = 1'b0;
        d.rvalid = 1'b0;
        d.rb1 = ready_busy_n;
        d.rb2 = q.rb1;
        case (q.st)
            FCM_ST_IDLE: begin
                d.rdy = 1'b1;
                if (req_valid && q.rdy) begin
                    d.rdy = 1'b0;
                    d.op = req_op;
                    d.addr = req_addr;
                    d.data = req_data;
                    d.step = 2'd0;
                    d.tout = 1'b0;
                    d.st = FCM_ST_ISSUE;
                end
            end
            FCM_ST_ISSUE: begin
                d.wr = 1'b1;
                d.baddr = q.addr;
                d.bdata = q.data;
                case (q.op)
                    // reset at the caller's address, any is accepted
                    // reset leaves autoselect and error status
                    FCM_OP_RESET: d.bdata = cmd(CMD_RESET);
                    FCM_OP_READ:  d.wr = 1'b0;
                    // bypass program and bypass exit issued whether or not in bypass
                    FCM_OP_BYP_PROG: begin
                        if (q.step == 2'd0) d.bdata = cmd(FCM_CMD_BYP_PROG);
                    end
                    FCM_OP_BYP_EXIT: begin
                        d.bdata = (q.step == 2'd0) ? cmd(FCM_CMD_BYP_EXIT1)
                                                   : cmd(FCM_CMD_BYP_EXIT2);
                    end
                    default: begin
                        // exact unlock pairs and set-up values
                        case (q.step)
                            2'd0: begin
                                d.baddr = AW'(UNLOCK1_ADDR);
                                d.bdata = cmd(UNLOCK1_DATA);
                            end
                            2'd1: begin
                                d.baddr = AW'(UNLOCK2_ADDR);
                                d.bdata = cmd(UNLOCK2_DATA);
                            end
                            2'd2: begin
                                d.baddr = AW'(UNLOCK1_ADDR);
                                if (q.op == FCM_OP_AUTOSEL) d.bdata = cmd(CMD_AUTOSEL);
                                else if (q.op == FCM_OP_PROGRAM) d.bdata = cmd(CMD_PROG);
                                else d.bdata = cmd(FCM_CMD_BYP_ENTER);
                            end
                            default: ;
                        endcase
                    end
                endcase
                d.start = 1'b1;
                d.st = FCM_ST_WAIT_BUS;
            end
            FCM_ST_WAIT_BUS: begin
                if (bus_done) begin
                    if (q.step != last_step(q.op)) begin
                        d.step = q.step + 2'd1;
                        d.st = FCM_ST_ISSUE;
                    end else if (q.op == FCM_OP_PROGRAM || q.op == FCM_OP_BYP_PROG) begin
                        d.wait_cnt = 17'(BUSY_WAIT);
                        d.st = FCM_ST_WAIT_BUSY;
                    end else begin
                        d.st = FCM_ST_FINISH;
                    end
                end
            end
            // wait for busy to show, then for ready
            FCM_ST_WAIT_BUSY: begin
                d.wait_cnt = q.wait_cnt - 17'd1;
                if (!q.rb2) begin
                    d.wait_cnt = 17'(BUSY_TIMEOUT);
                    d.st = FCM_ST_WAIT_READY;
                end else if (q.wait_cnt == 17'd0) begin
                    d.st = FCM_ST_FINISH;
                end
            end
            // no command written while programming runs
            FCM_ST_WAIT_READY: begin
                d.wait_cnt = q.wait_cnt - 17'd1;
                if (q.rb2) begin
                    d.st = FCM_ST_FINISH;
                end else if (q.wait_cnt == 17'd0) begin
                    d.tout = 1'b1;
                    d.st = FCM_ST_FINISH;
                end
            end
            FCM_ST_FINISH: begin
                d.rvalid = 1'b1;
                d.rdata = bus_rdata;
                case (q.op)
                    FCM_OP_RESET:     d.asel = 1'b0;
                    FCM_OP_AUTOSEL:   d.asel = 1'b1;
                    FCM_OP_BYP_ENTER: d.byp = 1'b1;
                    FCM_OP_BYP_EXIT:  d.byp = 1'b0;
                    default: ;
                endcase
                d.st = FCM_ST_IDLE;
            end
            default: d.st = FCM_ST_IDLE;
        endcase
        if (srst) begin
            d = '0;
            d.st = FCM_ST_IDLE;
            d.rb1 = 1'b1;
            d.rb2 = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    fcm_bus_cycle #(
        .AW (AW),
        .DW (DW)
    ) u_bus (
        .clock      (clock),
        .srst       (srst),
        .start      (q.start),
        .is_write   (q.wr),
        .addr       (q.baddr),
        .wdata      (q.bdata),
        .done       (bus_done),
        .rdata      (bus_rdata),
        .flash_addr (flash_addr),
        .chip_sel_n (chip_sel_n),
        .out_en_n   (out_en_n),
        .write_n    (write_n),
        .dq_out     (dq_out),
        .dq_oe      (dq_oe),
        .dq_in      (dq_in)
    );

    assign req_ready     = q.rdy;
    assign resp_valid    = q.rvalid;
    assign resp_data     = q.rdata;
    assign resp_timeout  = q.tout;
    assign in_bypass     = q.byp;
    assign in_autoselect = q.asel;

endmodule
`default_nettype wire

// ### fcm_host_asserts.sv
// Pin and handshake checks for the flash command host.
// Assumes the host runs on one clock with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module fcm_host_asserts (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // User side
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        resp_valid,
    input wire logic        resp_timeout,
    input wire logic        in_bypass,
    input wire logic        in_autoselect,
    // Flash pins
    input wire logic [18:0] flash_addr,
    input wire logic        chip_sel_n,
    input wire logic        out_en_n,
    input wire logic        write_n,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        ready_busy_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    wr_qualify_a: assert property (!write_n |-> out_en_n && !chip_sel_n)
        else $error("write strobe without select or with output enable");
    rd_nodrive_a: assert property (!out_en_n |-> !dq_oe && write_n)
        else $error("data bus driven during a read");
    wr_data_a: assert property ($rose(write_n) |-> dq_oe && $stable(dq_out))
        else $error("write data not held at strobe rise");
    addr_hold_a: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(flash_addr))
        else $error("address moved while selected");
    pulse_len_a: assert property ($fell(write_n) |->
        (!write_n)[*8] ##1 !write_n ##1 !write_n ##1 write_n)
        else $error("write pulse length wrong");
    busy_quiet_a: assert property (!ready_busy_n |-> write_n)
        else $error("write issued while flash busy");
    busy_resp_a: assert property (resp_valid && !resp_timeout |->
        ready_busy_n && $past(ready_busy_n))
        else $error("answer given while flash busy");
    reset_idle_a: assert property ($past(srst) |-> write_n && chip_sel_n && !dq_oe && !req_ready)
        else $error("pins active straight after reset");
    take_once_a: assert property (req_valid && req_ready |=> !req_ready)
        else $error("second request accepted while busy");

    cover property ($fell(write_n));
    cover property ($rose(resp_timeout));
    cover property ($rose(in_autoselect));
    cover property ($rose(in_bypass));
endmodule

bind fcm_host fcm_host_asserts u_fcm_chk (
    .clock(clock), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_timeout(resp_timeout), .in_bypass(in_bypass),
    .in_autoselect(in_autoselect), .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_n(write_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .ready_busy_n(ready_busy_n)
);
`default_nettype wire

// ### fcm_flash_model.sv
// Behavioural parallel NOR flash: command decoder, 256-word array, busy pin.
// Assumes the host keeps write cycles whole; hang holds busy for timeout tests.
`timescale 1ns/1ns
`default_nettype none
module fcm_flash_model #(
    parameter logic [15:0] MAKER_ID    = 16'h00c3, // arbitrary value
    parameter logic [15:0] DEVICE_ID   = 16'h2a5e, // arbitrary value
    parameter logic [2:0]  PROT_SECTOR = 3'h1,
    parameter int          BUSY_NS     = 120
) (
    // Flash pins
    input wire logic [18:0] flash_addr,
    input wire logic        chip_sel_n,
    input wire logic        out_en_n,
    input wire logic        write_n,
    input wire logic [15:0] dq_out,
    output logic [15:0]     dq_in,
    output logic            ready_busy_n,
    // Test control
    input wire logic        hang,
    input wire logic        lockout
);
    logic [15:0] mem [256];
    logic [18:0] a_l;
    logic [15:0] d_l;
    logic [7:0]  c;
    logic        autosel = 0, bypass = 0, busy = 0;
    int          step = 0;
    wire wcyc = !chip_sel_n && !write_n && out_en_n;
    wire rd   = !chip_sel_n && !out_en_n;

    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        dq_in = 16'h0000;
    end
    assign ready_busy_n = !busy;
    always @(posedge wcyc) a_l = flash_addr;
    always @(negedge wcyc) begin
        d_l = dq_out;
        c = dq_out[7:0];
        // ignore while busy or locked out
        if (!busy && !lockout) begin
            if (bypass) begin
                if (step == 3) begin busy = 1; step = 0; end
                else if (step == 4) begin bypass = (c != 8'h00); step = 0; end
                else step = (c == 8'ha0) ? 3 : (c == 8'h90) ? 4 : 0;
            end
            else if (c == 8'hf0 && step != 3) begin step = 0; autosel = 0; end
            else if (step == 3) begin busy = 1; step = 0; end
            else if (step == 0 && a_l == 19'h00555 && c == 8'haa) step = 1;
            else if (step == 1 && a_l == 19'h002aa && c == 8'h55) step = 2;
            else if (step == 2 && c == 8'h90) begin autosel = 1; step = 0; end
            else if (step == 2 && c == 8'ha0) step = 3;
            else if (step == 2 && c == 8'h20) begin bypass = 1; step = 0; end
            else step = 0;
        end
    end
    always @(posedge lockout) begin
        step = 0;
        autosel = 0;
        bypass = 0;
    end
    always @(posedge busy) begin
        #(BUSY_NS);
        wait (!hang);
        mem[a_l[7:0]] = mem[a_l[7:0]] & d_l;
        busy = 0;
    end
    always @(rd or flash_addr or autosel or busy)
        if (rd) dq_in = !autosel ? mem[flash_addr[7:0]] :
            (flash_addr[7:0] == 8'h00) ? MAKER_ID :
            (flash_addr[7:0] == 8'h01) ? DEVICE_ID :
            {15'h0000, flash_addr[18:16] == PROT_SECTOR};
    // Released bus shows no stale value
    always @(negedge rd) dq_in = ~dq_in;
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the flash command host against a flash model.
// Assumes short busy wait and timeout parameters to keep the run brief.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fcm_pkg::*;
    localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
    localparam logic [15:0] DEVID = 16'h2a5e; // arbitrary value
    logic        clock = 0, srst = 1, req_valid = 0, hang = 0, lockout = 0;
    logic [3:0]  req_op = 4'h0;
    logic [18:0] req_addr = 19'h00000, flash_addr;
    logic [15:0] req_data = 16'h0000, resp_data, dq_out, dq_in;
    logic        req_ready, resp_valid, resp_timeout, in_bypass, in_autoselect;
    logic        chip_sel_n, out_en_n, write_n, dq_oe, ready_busy_n;
    int          num_errors = 0, checks_done = 0;

    always #2 clock = ~clock;

    fcm_host #(.BUSY_WAIT(8), .BUSY_TIMEOUT(200)) dut (
        .clock(clock), .srst(srst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_timeout(resp_timeout),
        .in_bypass(in_bypass), .in_autoselect(in_autoselect), .flash_addr(flash_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));

    fcm_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID)) u_flash (
        .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_n(write_n), .dq_out(dq_out), .dq_in(dq_in),
        .ready_busy_n(ready_busy_n), .hang(hang), .lockout(lockout));

    task automatic wrap_up();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Settled level sampled at falling edges, bounded
    task automatic wait_hi(input int sel, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((sel == 0 ? req_ready : resp_valid) !== 1'b1 && n < lim);
        if ((sel == 0 ? req_ready : resp_valid) !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
    endtask

    task automatic do_op(input logic [3:0] op, input logic [18:0] a, input logic [15:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        wait_hi(0, 100);
        @(posedge clock);
        req_valid <= 1'b0;
        wait_hi(1, 2000);
    endtask

    task automatic rd(input logic [18:0] a, input logic [15:0] exp);
        do_op(FCM_OP_READ, a, 16'h0000);
        check(resp_data, exp);
    endtask

    task automatic t_program();
        do_op(FCM_OP_PROGRAM, 19'h00010, 16'h1234);
        check({15'h0, resp_timeout}, 16'h0000);
        rd(19'h00010, 16'h1234);
        do_op(FCM_OP_PROGRAM, 19'h00010, 16'hff0f);
        rd(19'h00010, 16'h1204);
        $display("program test done");
    endtask

    task automatic t_autosel();
        do_op(FCM_OP_AUTOSEL, 19'h00000, 16'h0000);
        check({15'h0, in_autoselect}, 16'h0001);
        rd(19'h00000, MAKER);
        rd(19'h00001, DEVID);
        rd(19'h10002, 16'h0001);
        rd(19'h20002, 16'h0000);
        rd(19'h50000, MAKER);
        do_op(FCM_OP_RESET, 19'h7abcd, 16'h0000);
        check({15'h0, in_autoselect}, 16'h0000);
        rd(19'h00010, 16'h1204);
        $display("autoselect test done");
    endtask

    task automatic t_bypass();
        do_op(FCM_OP_BYP_ENTER, 19'h00000, 16'h0000);
        check({15'h0, in_bypass}, 16'h0001);
        do_op(FCM_OP_BYP_PROG, 19'h00020, 16'ha5a5);
        do_op(FCM_OP_BYP_PROG, 19'h00021, 16'h0f0f);
        do_op(FCM_OP_BYP_EXIT, 19'h00000, 16'h0000);
        check({15'h0, in_bypass}, 16'h0000);
        rd(19'h00020, 16'ha5a5);
        rd(19'h00021, 16'h0f0f);
        $display("bypass test done");
    endtask

    task automatic t_lockout();
        lockout <= 1'b1;
        do_op(FCM_OP_AUTOSEL, 19'h00000, 16'h0000);
        rd(19'h00000, 16'hffff);
        lockout <= 1'b0;
        do_op(FCM_OP_RESET, 19'h00000, 16'h0000);
        check({15'h0, in_autoselect}, 16'h0000);
        $display("lockout test done");
    endtask

    task automatic t_timeout();
        hang <= 1'b1;
        do_op(FCM_OP_PROGRAM, 19'h00030, 16'h0000);
        check({15'h0, resp_timeout}, 16'h0001);
        hang <= 1'b0;
        repeat (4) @(posedge clock);
        rd(19'h00030, 16'h0000);
        $display("timeout test done");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        check(16'({write_n, chip_sel_n, out_en_n, dq_oe, req_ready}), 16'h001c);
        @(posedge clock);
        srst <= 1'b0;
        rd(19'h00005, 16'hffff);
        $display("reset test done");
        t_program();
        t_autosel();
        t_bypass();
        t_lockout();
        t_timeout();
        wrap_up();
    end
endmodule
`default_nettype wire
